// File: include/ppc_pkg.sv
// package for the priority pin crossbar: register map, field positions, sizes
`default_nettype none
package ppc_pkg;
  // sizes
  localparam int NUM_PINS = 32;
  localparam int NUM_SIGS = 33;
  localparam int RANK_W = 6;
  // register byte addresses
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CFG2 = 8'h08;
  localparam logic [7:0] ADDR_CFG3 = 8'h0C;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h10;
  localparam logic [7:0] ADDR_P1_MODE = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h1C;
  localparam logic [7:0] ADDR_CLAIMED = 8'h20;
  // values after reset
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [31:0] RST_PORT_DATA = 32'hFFFFFFFF;
  localparam logic [7:0] RST_P1_MODE = 8'hFF;
  localparam logic [1:0] RST_CTRL = 2'h0;
  // crossbar_config_0 fields
  localparam int C0_SMBUS = 0;
  localparam int C0_SPI = 1;
  localparam int C0_PRI_UART = 2;
  localparam int C0_CEX_LO = 3;
  localparam int C0_CEX_HI = 5;
  localparam int C0_ECI = 6;
  localparam int C0_CMP0 = 7;
  // crossbar_config_1 fields
  localparam int C1_CMP1 = 0;
  localparam int C1_TMR0 = 1;
  localparam int C1_IRQ0 = 2;
  localparam int C1_TMR1 = 3;
  localparam int C1_IRQ1 = 4;
  localparam int C1_TMR2 = 5;
  localparam int C1_TMR2_EXT = 6;
  localparam int C1_SYSTEM_CLOCK_OUTPUT = 7;
  // crossbar_config_2 fields
  localparam int C2_CNV0 = 0;
  localparam int C2_SEC_UART = 2;
  localparam int C2_TMR4 = 3;
  localparam int C2_TMR4_EXT = 4;
  // crossbar_config_3 fields
  localparam int C3_TMR3 = 0;
  localparam int C3_TMR3_EXT = 1;
  localparam int C3_CNV2 = 2;
  localparam int C3_CMP2 = 3;
  // control register fields
  localparam int CTRL_EXT_MEM_LOW = 0;
  localparam int CTRL_SPI_3WIRE = 1;
  // pins owned by the memory interface when low-port select is set (port 0 bits 5..7)
  localparam logic [31:0] EXT_MEM_PIN_MASK = 32'h000000E0;
  localparam int PORT1_LSB = 8;
  // signal slots in priority order
  localparam int S_PRI_UART = 0;
  localparam int S_SPI = 2;
  localparam int S_SPI_SEL = 5;
  localparam int S_SMBUS = 6;
  localparam int S_SEC_UART = 8;
  localparam int S_CEX = 10;
  localparam int N_CEX = 6;
  localparam int S_ECI = 16;
  localparam int S_CMP0 = 17;
  localparam int S_CMP1 = 18;
  localparam int S_CMP2 = 19;
  localparam int S_TMR0 = 20;
  localparam int S_IRQ0 = 21;
  localparam int S_TMR1 = 22;
  localparam int S_IRQ1 = 23;
  localparam int S_TMR2 = 24;
  localparam int S_TMR2_EXT = 25;
  localparam int S_TMR3 = 26;
  localparam int S_TMR3_EXT = 27;
  localparam int S_TMR4 = 28;
  localparam int S_TMR4_EXT = 29;
  localparam int S_SYSTEM_CLOCK_OUTPUT = 30;
  localparam int S_CNV0 = 31;
  localparam int S_CNV2 = 32;
  // pad drive bundle: level and output enable per pin
  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] oe;
  } ppc_drive_s;
endpackage : ppc_pkg
`default_nettype wire

// File: rtl/ppc_crossbar.sv
// priority pin crossbar with apb configuration and port data registers
//
// Design decisions made here: register access over APB and the address map.
`default_nettype none
// How it works
// - route a peripheral only while enabled
// - primary uart enable puts tx/rx on p0.0/p0.1
// - primary uart holds first two pins whenever enabled
// - disabled peripheral touches no pin
// - serial units claim all their pins together
// - unclaimed pins left in the pool act as port-data gpio
// - memory low-port and analog port1 pins skipped
module ppc_crossbar
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral side, one slot per signal in priority order
  input wire logic [ppc_pkg::NUM_SIGS-1:0] periph_out,
  input wire logic [ppc_pkg::NUM_SIGS-1:0] periph_oe,
  output logic [ppc_pkg::NUM_SIGS-1:0] periph_in,
  output logic [ppc_pkg::NUM_SIGS-1:0] periph_granted,
  // port pins 0..3, three signals per pin
  input wire logic [ppc_pkg::NUM_PINS-1:0] pin_in,
  output logic [ppc_pkg::NUM_PINS-1:0] pin_out,
  output logic [ppc_pkg::NUM_PINS-1:0] pin_oe
);
  import ppc_pkg::*;

  // configuration state
  logic [7:0] crossbar_config_0; // serial, counter-array, comparator 0 enables
  logic [7:0] crossbar_config_1; // comparator 1, timer, irq, clock-out enables
  logic [7:0] crossbar_config_2; // conversion 0, second uart, timer 4 enables
  logic [7:0] crossbar_config_3; // timer 3, conversion 2, comparator 2 enables
  logic [31:0] port_data; // gpio latches, byte per port
  logic [7:0] port1_input_mode; // 1 = digital, 0 = analog
  logic [1:0] ctrl; // low-port select and spi three-wire
  logic ext_memory_low_port_select; // memory interface takes port 0 upper pins
  // pin input synchroniser
  logic [NUM_PINS-1:0] pin_meta; // first stage, read only by second stage
  logic [NUM_PINS-1:0] pin_sync; // safe pin levels
  // allocation results
  logic [NUM_SIGS-1:0] sig_en; // per-signal enable
  logic [RANK_W-1:0] sig_rank [NUM_SIGS]; // enabled signals ahead of each slot
  logic [RANK_W-1:0] free_rank [NUM_PINS]; // free pins ahead of each pin
  logic [NUM_PINS-1:0] pin_free; // pin available to the crossbar
  logic [NUM_PINS-1:0] claimed; // pin taken by a peripheral
  logic [RANK_W-1:0] sel [NUM_PINS]; // slot that owns each pin
  ppc_drive_s next_drive; // pad drive before the output flops
  logic [NUM_SIGS-1:0] next_periph_in; // peripheral inputs before flops
  logic [NUM_SIGS-1:0] next_granted; // slots that hold a pin
  // apb decode
  logic setup_phase; // first cycle of a transfer
  logic wr_fire; // write accepted this edge
  logic [31:0] next_prdata; // read mux
  logic next_err; // unmapped address

  assign ext_memory_low_port_select = ctrl[CTRL_EXT_MEM_LOW];
  assign setup_phase = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;

  // per-signal enables from the configuration registers
  always_comb
  begin
    sig_en = '0;
    sig_en[S_PRI_UART +: 2] = {2{crossbar_config_0[C0_PRI_UART]}};
    sig_en[S_SPI +: 3] = {3{crossbar_config_0[C0_SPI]}};
    // select line stays off the pins in three-wire mode
    sig_en[S_SPI_SEL] = crossbar_config_0[C0_SPI] & ~ctrl[CTRL_SPI_3WIRE];
    sig_en[S_SMBUS +: 2] = {2{crossbar_config_0[C0_SMBUS]}};
    sig_en[S_SEC_UART +: 2] = {2{crossbar_config_2[C2_SEC_UART]}};
    // counter-array outputs enabled as a count from the first one
    for (int k = 0; k < N_CEX; k++)
    begin
      sig_en[S_CEX + k] = (crossbar_config_0[C0_CEX_HI:C0_CEX_LO] > 3'(k));
    end
    sig_en[S_ECI] = crossbar_config_0[C0_ECI];
    sig_en[S_CMP0] = crossbar_config_0[C0_CMP0];
    sig_en[S_CMP1] = crossbar_config_1[C1_CMP1];
    sig_en[S_CMP2] = crossbar_config_3[C3_CMP2];
    sig_en[S_TMR0] = crossbar_config_1[C1_TMR0];
    sig_en[S_IRQ0] = crossbar_config_1[C1_IRQ0];
    sig_en[S_TMR1] = crossbar_config_1[C1_TMR1];
    sig_en[S_IRQ1] = crossbar_config_1[C1_IRQ1];
    sig_en[S_TMR2] = crossbar_config_1[C1_TMR2];
    sig_en[S_TMR2_EXT] = crossbar_config_1[C1_TMR2_EXT];
    sig_en[S_TMR3] = crossbar_config_3[C3_TMR3];
    sig_en[S_TMR3_EXT] = crossbar_config_3[C3_TMR3_EXT];
    sig_en[S_TMR4] = crossbar_config_2[C2_TMR4];
    sig_en[S_TMR4_EXT] = crossbar_config_2[C2_TMR4_EXT];
    sig_en[S_SYSTEM_CLOCK_OUTPUT] = crossbar_config_1[C1_SYSTEM_CLOCK_OUTPUT];
    sig_en[S_CNV0] = crossbar_config_2[C2_CNV0];
    sig_en[S_CNV2] = crossbar_config_3[C3_CNV2];
  end

  // pins that the crossbar may hand out
  always_comb
  begin
    pin_free = '1;
    // memory interface pins leave the pool
    if (ext_memory_low_port_select)
    begin
      pin_free = pin_free & ~EXT_MEM_PIN_MASK;
    end
    // analog port 1 pins leave the pool
    pin_free[PORT1_LSB +: 8] = port1_input_mode;
  end

  // ranks: position of each enabled slot and of each free pin
  always_comb
  begin
    logic [RANK_W-1:0] acc_s;
    logic [RANK_W-1:0] acc_p;
    acc_s = '0;
    acc_p = '0;
    // slots count in strict priority order, uart first
    for (int s = 0; s < NUM_SIGS; s++)
    begin
      sig_rank[s] = acc_s;
      acc_s = acc_s + RANK_W'(sig_en[s]);
    end
    // free pins count from port 0 bit 0 upward
    for (int p = 0; p < NUM_PINS; p++)
    begin
      free_rank[p] = acc_p;
      acc_p = acc_p + RANK_W'(pin_free[p]);
    end
  end

  // match the n-th enabled slot to the n-th free pin
  always_comb
  begin
    claimed = '0;
    next_granted = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      sel[p] = '0;
      for (int s = 0; s < NUM_SIGS; s++)
      begin
        // only an enabled slot may win a pin
        if (sig_en[s] && pin_free[p] && (sig_rank[s] == free_rank[p]))
        begin
          claimed[p] = 1'b1;
          sel[p] = RANK_W'(s);
          next_granted[s] = 1'b1;
        end
      end
    end
  end

  // pad drive: peripheral, gpio latch, or released
  always_comb
  begin
    next_drive = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      if (claimed[p])
      begin
        // owning peripheral drives the pad
        next_drive.level[p] = periph_out[sel[p]];
        next_drive.oe[p] = periph_oe[sel[p]];
      end
      else if (pin_free[p])
      begin
        // quasi-bidirectional gpio: a 0 pulls low, a 1 releases
        next_drive.level[p] = port_data[p];
        next_drive.oe[p] = ~port_data[p];
      end
      else
      begin
        // pin belongs to memory interface or analog input
        next_drive.level[p] = 1'b0;
        next_drive.oe[p] = 1'b0;
      end
    end
  end

  // peripheral inputs come only from their own pin, idle high otherwise
  always_comb
  begin
    next_periph_in = '1;
    for (int s = 0; s < NUM_SIGS; s++)
    begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
        if (claimed[p] && (sel[p] == RANK_W'(s)))
        begin
          next_periph_in[s] = pin_sync[p];
        end
      end
    end
  end

  // two-stage synchroniser on the pads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '1;
      pin_sync <= '1;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // registered pad drive and peripheral side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= '0;
      pin_oe <= '0;
      periph_in <= '1;
      periph_granted <= '0;
    end
    else
    begin
      pin_out <= next_drive.level;
      pin_oe <= next_drive.oe;
      periph_in <= next_periph_in;
      periph_granted <= next_granted;
    end
  end

  // configuration register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crossbar_config_0 <= RST_CFG;
      crossbar_config_1 <= RST_CFG;
      crossbar_config_2 <= RST_CFG;
      crossbar_config_3 <= RST_CFG;
      port_data <= RST_PORT_DATA;
      port1_input_mode <= RST_P1_MODE;
      ctrl <= RST_CTRL;
    end
    else if (wr_fire)
    begin
      case (paddr)
        ADDR_CFG0: crossbar_config_0 <= pwdata[7:0];
        ADDR_CFG1: crossbar_config_1 <= pwdata[7:0];
        ADDR_CFG2: crossbar_config_2 <= pwdata[7:0];
        ADDR_CFG3: crossbar_config_3 <= pwdata[7:0];
        ADDR_PORT_DATA: port_data <= pwdata;
        ADDR_P1_MODE: port1_input_mode <= pwdata[7:0];
        ADDR_CTRL: ctrl <= pwdata[1:0];
        default: ; // read-only or unmapped: no effect
      endcase
    end
  end

  // read mux and address check
  always_comb
  begin
    next_prdata = '0;
    next_err = 1'b0;
    case (paddr)
      ADDR_CFG0: next_prdata = {24'h000000, crossbar_config_0};
      ADDR_CFG1: next_prdata = {24'h000000, crossbar_config_1};
      ADDR_CFG2: next_prdata = {24'h000000, crossbar_config_2};
      ADDR_CFG3: next_prdata = {24'h000000, crossbar_config_3};
      ADDR_PORT_DATA: next_prdata = port_data;
      ADDR_P1_MODE: next_prdata = {24'h000000, port1_input_mode};
      ADDR_CTRL: next_prdata = {30'h00000000, ctrl};
      ADDR_PIN_LEVEL: next_prdata = pin_sync;
      ADDR_CLAIMED: next_prdata = claimed;
      default: next_err = 1'b1;
    endcase
  end

  // apb answer: one wait-free access cycle, response prepared in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase & next_err;
      // read data captured in setup, cleared otherwise
      if (setup_phase && !pwrite)
      begin
        prdata <= next_prdata;
      end
      else
      begin
        prdata <= '0;
      end
    end
  end

endmodule : ppc_crossbar
`default_nettype wire

// File: tb/ppc_crossbar_asserts.sv
// port checker for the priority pin crossbar
`default_nettype none
module ppc_crossbar_asserts
  import ppc_pkg::*;
(
  // clock and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // peripherals and pads
  input wire logic [ppc_pkg::NUM_SIGS-1:0] periph_out,
  input wire logic [ppc_pkg::NUM_SIGS-1:0] periph_oe,
  input wire logic [ppc_pkg::NUM_SIGS-1:0] periph_in,
  input wire logic [ppc_pkg::NUM_SIGS-1:0] periph_granted,
  input wire logic [ppc_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [ppc_pkg::NUM_PINS-1:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer is a single cycle pulse
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  // answer only follows a setup cycle
  a_ready_after_setup: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  // error only with the answer
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  // read bus idles at zero
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  // uart pins granted together
  a_uart_pair: assert property (periph_granted[0] == periph_granted[1])
    else $error("uart split");
  // other serial units granted whole
  a_serial_whole: assert property (periph_granted[4:2] inside {3'h0, 3'h7}
    && periph_granted[7] == periph_granted[6] && periph_granted[9] == periph_granted[8])
    else $error("serial split");
  // slot without a pin reads high
  a_idle_slot_high: assert property (&(periph_in | periph_granted))
    else $error("idle slot low");
  // uart stays on the first two pads
  a_uart_fixed: assert property (periph_granted[0] && $past(periph_granted[0])
    |-> pin_out[1:0] == $past(periph_out[1:0]) && pin_oe[1:0] == $past(periph_oe[1:0]))
    else $error("uart pads moved");
  // main scenarios reached
  c_err: cover property (pslverr);
  c_uart: cover property (periph_granted[0]);
  c_system_clock_output: cover property (periph_granted[S_SYSTEM_CLOCK_OUTPUT]);
endmodule : ppc_crossbar_asserts
bind ppc_crossbar ppc_crossbar_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
  .periph_granted(periph_granted), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// File: tb/ppc_pin_far.sv
// far side of the pads: external lines with pull-ups
`default_nettype none
module ppc_pin_far
(
  // pad drive from the crossbar
  input wire logic [ppc_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [ppc_pkg::NUM_PINS-1:0] pin_oe,
  // external circuit pulling a pin low
  input wire logic [ppc_pkg::NUM_PINS-1:0] ext_low,
  // resolved pad levels
  output logic [ppc_pkg::NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import ppc_pkg::*;
  // driven pads follow the crossbar, released pads go to pull-up or external low
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
endmodule : ppc_pin_far
`default_nettype wire

// File: tb/test_priority_pin_crossbar.sv
// self-checking bench for the priority pin crossbar
`default_nettype none
module test_priority_pin_crossbar
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [NUM_SIGS-1:0] p_out, p_oe, p_in, p_gnt;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, ext_low;
  logic [31:0] exp_q[$]; // expected read data
  logic [7:0] rst_a[8] = '{ADDR_CFG0, ADDR_CFG1, ADDR_CFG2, ADDR_CFG3, ADDR_PORT_DATA,
    ADDR_P1_MODE, ADDR_CTRL, 8'h24};
  logic [31:0] rst_v[8] = '{0, 0, 0, 0, RST_PORT_DATA, 32'hFF, 0, 0};
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  logic exp_err; // unmapped address expected on the current access
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ppc_crossbar i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
    .periph_granted(p_gnt), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  ppc_pin_far i_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low), .pin_in(pin_in));
  // compare a pad or grant value
  task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk_pin
  // compare read data
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    check_count++;
    if (prdata !== e)
    begin
      mismatches++;
      $display("wrong value reg %h exp %h got %h", a, e, prdata);
    end
  endtask : chk_reg
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is sampled at the rising edge, request still standing
    do @(posedge pclk); while (pready !== 1'b1);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read with expected value noted
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // let pads and synchronisers settle
  task automatic settle;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  // verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // transfer monitor: error flag on every access, oldest note on reads
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      exp_err = !(paddr inside {ADDR_CFG0, ADDR_CFG1, ADDR_CFG2, ADDR_CFG3, ADDR_PORT_DATA,
        ADDR_P1_MODE, ADDR_CTRL, ADDR_PIN_LEVEL, ADDR_CLAIMED});
      chk_pin("slverr", 32'(exp_err), 32'(pslverr));
      if (!pwrite)
        chk_reg(paddr, exp_q.pop_front());
    end
  // hang limit
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      wrap_up;
    end
  end
  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {p_out, p_oe, ext_low} = '0;
    void'($urandom(32'h3820));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
    $display("test reset done");
    p_out <= 33'({$urandom, $urandom});
    p_oe <= 33'h1FFFFFFFD; // rx slot listens
    ext_low <= 32'h2;
    apb(1'b1, ADDR_CFG0, 32'h04);
    settle;
    chk_pin("uart grant", 32'h3, 32'(p_gnt));
    chk_pin("uart tx", 32'(p_out[0]), 32'(pin_out[0]));
    chk_pin("uart rx", 32'h0, 32'(p_in[1]));
    $display("test uart done");
    apb(1'b1, ADDR_CFG0, 32'h07);
    apb(1'b1, ADDR_CFG2, 32'h04);
    settle;
    chk_pin("serial grant", 32'h3FF, 32'(p_gnt));
    chk_pin("serial out", 32'(p_out[9:0]), 32'(pin_out[9:0]));
    chk_pin("serial oe", 32'(p_oe[9:0]), 32'(pin_oe[9:0]));
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_P1_MODE, 32'h0);
    settle;
    chk_pin("removed oe", 32'h0, 32'(pin_oe[15:5]));
    chk_pin("moved out", 32'(p_out[9:5]), 32'(pin_out[20:16]));
    $display("test serial done");
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_P1_MODE, 32'hFF);
    apb(1'b1, ADDR_CFG0, 32'h80);
    apb(1'b1, ADDR_CFG1, 32'h80);
    apb(1'b1, ADDR_CFG2, 32'h0);
    settle;
    chk_pin("order", 32'({p_out[S_SYSTEM_CLOCK_OUTPUT], p_out[S_CMP0]}), 32'(pin_out[1:0]));
    chk_pin("order grant", 32'h40020000, 32'(p_gnt));
    rd(ADDR_CLAIMED, 32'h3);
    $display("test order done");
    // three-wire spi drops its select slot; two counter-array outputs follow
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_CFG1, 32'h0);
    apb(1'b1, ADDR_CFG0, 32'h12);
    settle;
    chk_pin("3wire grant", 32'h00000C1C, 32'(p_gnt));
    chk_pin("3wire out", 32'({p_out[11:10], p_out[4:2]}), 32'(pin_out[4:0]));
    $display("test three-wire done");
    d = $urandom;
    apb(1'b1, ADDR_CFG0, 32'h0);
    apb(1'b1, ADDR_CFG1, 32'h0);
    apb(1'b1, ADDR_PORT_DATA, d);
    settle;
    chk_pin("gpio oe", ~d, pin_oe);
    chk_pin("gpio out", 32'h0, pin_out & ~d);
    chk_pin("idle in", 32'hFFFFFFFF, 32'(p_in));
    rd(ADDR_PIN_LEVEL, d & ~32'h2);
    $display("test gpio done");
    // let the monitor take the last read before the verdict
    repeat (2) @(posedge pclk);
    wrap_up;
  end
endmodule : test_priority_pin_crossbar
`default_nettype wire
